// ==== bench/dic_chk.sv ====
// port assertions for dic_top
// assumes it is bound into dic_top
`timescale 1ns/10ps
`default_nettype none
module dic_chk #(
    parameter int unsigned NUM_IN = 8
) (
    input wire logic                           pclk,
    input wire logic                           presetn,
    input wire logic                           ce,
    input wire logic                           psel,
    input wire logic                           penable,
    input wire logic [dic_pkg::DIC_ADDR_W-1:0] paddr,
    input wire logic [dic_pkg::DIC_DATA_W-1:0] prdata,
    input wire logic                           pready,
    input wire logic                           pslverr,
    input wire logic                           alarm_in,
    input wire logic [NUM_IN-1:0]              input_filtered,
    input wire logic                           alarm_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_answer_a: assert property (psel && !penable && ce |=> pready)
        else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready stood too long");
    ready_cause_a: assert property (pready |-> $past(psel && !penable && ce))
        else $error("ready without setup");
    idle_data_a: assert property (!pready |-> prdata == '0)
        else $error("read data outside answer");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    addr_decode_a: assert property (psel && !penable && ce && paddr[1:0] == 2'b00
        |=> pslverr == (paddr > 8'h20)) else $error("wrong address decode");
    alarm_fall_a: assert property (ce && !alarm_in |=> !alarm_out)
        else $error("alarm did not fall");
    alarm_max_a: assert property ((ce && alarm_in) [*7] |=> alarm_out)
        else $error("alarm late");
    out_freeze_a: assert property (!ce |=> $stable(input_filtered) && $stable(alarm_out))
        else $error("outputs moved while frozen");
    cover property (pslverr);
    cover property ($rose(alarm_out));
    cover property (!ce ##1 ce);
endmodule
`default_nettype wire

// ==== bench/dic_pins_model.sv ====
// model of the connector switches and the alarm source
// assumes pclk from the bench; levels change just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module dic_pins_model (
    input  wire logic       pclk,
    output logic      [7:0] io_connector_in,
    output logic            alarm_in
);
    initial begin
        io_connector_in = 8'h00;
        alarm_in = 1'b0;
    end
    task set_pins(input logic [7:0] v);
        @(posedge pclk);
        io_connector_in <= v;
    endtask
    task set_alarm(input logic v);
        @(posedge pclk);
        alarm_in <= v;
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for dic_top over apb
// assumes dic_pkg, dic_chk and dic_pins_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import dic_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  io_connector_in;
    logic        alarm_in;
    logic [7:0]  input_filtered;
    logic        alarm_out;
    logic [31:0] rd;
    logic        er;
    int          n;
    int          failures = 0;
    int          checks_done = 0;
    int          nv[4] = '{0, 1, 4, 1000};
    logic [7:0]  ofs[5] = '{DIC_OFS_SEL_LOW, DIC_OFS_SEL_HIGH, DIC_OFS_FILT,
                            DIC_OFS_ALARM_FILT, DIC_OFS_INVERT1};
    logic [31:0] dv[5] = '{32'(DIC_RST_SEL_LOW), 32'(DIC_RST_SEL_HIGH), 32'(DIC_RST_FILT),
                           32'(DIC_RST_ALARM_FILT), 32'(DIC_RST_INVERT1)};
    always #5 pclk = ~pclk;
    dic_top i_dic_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .io_connector_in(io_connector_in), .alarm_in(alarm_in),
        .input_filtered(input_filtered), .alarm_out(alarm_out));
    dic_pins_model i_dic_pins_model (.pclk(pclk), .io_connector_in(io_connector_in),
        .alarm_in(alarm_in));
    task test_done;
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            failures++;
            test_done();
        end
    endtask
    task wait_obs(input int idx, input logic lvl, input int lim);
        logic [8:0] ob;
        n = 0;
        while (n <= lim) begin
            @(posedge pclk);
            #1;
            n++;
            ob = {alarm_out, input_filtered};
            if (ob[idx] === lvl)
                break;
        end
    endtask
    initial begin
        presetn <= 1'b0;
        ce <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            xfer(ofs[i], 1'b0, 32'h0);
            chk(rd, dv[i]);
        end
        xfer(8'h40, 1'b0, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        xfer(DIC_OFS_FILT, 1'b1, 32'd1001);
        xfer(DIC_OFS_FILT, 1'b0, 32'h0);
        chk(rd, 32'd1000);
        xfer(DIC_OFS_ALARM_FILT, 1'b1, 32'h7);
        xfer(DIC_OFS_ALARM_FILT, 1'b0, 32'h0);
        chk(rd, 32'h3);
        for (int i = 0; i < 4; i++) begin
            xfer(DIC_OFS_FILT, 1'b1, nv[i]);
            i_dic_pins_model.set_pins(8'h01);
            wait_obs(0, 1'b1, 1010);
            chk(n, nv[i] + 2);
            i_dic_pins_model.set_pins(8'h00);
            wait_obs(0, 1'b0, 1010);
            chk(n, nv[i] + 2);
            if (nv[i] > 0) begin
                i_dic_pins_model.set_pins(8'h01);
                repeat (nv[i] - 1) @(posedge pclk);
                i_dic_pins_model.set_pins(8'h00);
                wait_obs(0, 1'b1, nv[i] + 3);
                chk(n, nv[i] + 4);
            end
        end
        xfer(DIC_OFS_FILT, 1'b1, 32'h1);
        i_dic_pins_model.set_pins(8'h01);
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
        wait_obs(0, 1'b1, 20);
        chk(n, 3);
        i_dic_pins_model.set_pins(8'h00);
        for (int s = 0; s < 4; s++) begin
            xfer(DIC_OFS_ALARM_FILT, 1'b1, s);
            i_dic_pins_model.set_alarm(1'b1);
            wait_obs(8, 1'b1, 20);
            chk(n, 2 * s + 1);
            i_dic_pins_model.set_alarm(1'b0);
            wait_obs(8, 1'b0, 20);
            chk(n, 1);
        end
        xfer(DIC_OFS_FILT, 1'b1, 32'h0);
        xfer(DIC_OFS_BUS_VALUE, 1'b1, 32'hff);
        xfer(DIC_OFS_SEL_LOW, 1'b1, 32'h5);
        xfer(DIC_OFS_SEL_HIGH, 1'b1, 32'ha);
        xfer(DIC_OFS_INVERT1, 1'b1, 32'h3);
        xfer(DIC_OFS_ACTIVE, 1'b0, 32'h0);
        chk(rd[12:0], 13'h1000);
        chk(input_filtered, 8'h00);
        xfer(DIC_OFS_CONTROL, 1'b1, 32'h1);
        xfer(DIC_OFS_ACTIVE, 1'b0, 32'h0);
        chk(rd[12:0], 13'h03a5);
        repeat (4) @(posedge pclk);
        #1;
        chk(input_filtered, 8'ha6);
        i_dic_pins_model.set_pins(8'hff);
        repeat (4) @(posedge pclk);
        #1;
        chk(input_filtered, 8'hfc);
        xfer(DIC_OFS_STATUS, 1'b0, 32'h0);
        chk(rd[15:0], 16'hfcfc);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            xfer(ofs[i], 1'b0, 32'h0);
            chk(rd, dv[i]);
        end
        xfer(DIC_OFS_ACTIVE, 1'b0, 32'h0);
        chk(rd[12:0], 13'h0000);
        test_done();
    end
endmodule
bind dic_top dic_chk #(.NUM_IN(NUM_IN)) i_dic_chk (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarm_in(alarm_in),
    .input_filtered(input_filtered), .alarm_out(alarm_out));
`default_nettype wire

// ==== rtl/dic_filter.sv ====
// one-input glitch filter with a programmable hold count
// assumes raw is synchronous to clk; limit may change at any time
`timescale 1ns/10ps
`default_nettype none
module dic_filter #(
    parameter int unsigned CNT_W = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             raw,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  filtered
);
    logic [CNT_W-1:0] held;
    logic [CNT_W-1:0] next_held;
    logic             next_filtered;

    // held counts earlier cycles in which raw already differed
    always_comb begin
        next_held     = held;
        next_filtered = filtered;
        if (raw == filtered) begin
            next_held = '0;
        end else if (held >= limit) begin
            next_filtered = raw;
            next_held     = '0;
        end else begin
            next_held = held + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held     <= '0;
            filtered <= 1'b0;
        end else if (ce) begin
            held     <= next_held;
            filtered <= next_filtered;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/dic_top.sv ====
// digital input conditioning: source select, inversion, glitch filter, alarm filter
// assumes an apb master on pclk, connector pins synchronous to pclk
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dic_top #(
    parameter int unsigned FILT_W  = dic_pkg::DIC_FILT_W,
    parameter int unsigned NUM_IN  = dic_pkg::DIC_NUM_IN
) (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            ce,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [dic_pkg::DIC_ADDR_W-1:0]  paddr,
    input  wire logic [dic_pkg::DIC_DATA_W-1:0]  pwdata,
    output logic      [dic_pkg::DIC_DATA_W-1:0]  prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic [NUM_IN-1:0]               io_connector_in,
    input  wire logic                            alarm_in,
    output logic      [NUM_IN-1:0]               input_filtered,
    output logic                                 alarm_out
);
    import dic_pkg::*;

    localparam int unsigned GW = DIC_GROUP_W;

    // staged settings written by software
    logic [GW-1:0]     sel_low;
    logic [GW-1:0]     sel_high;
    logic [15:0]       filt_cycles;
    logic [15:0]       alarm_filt;
    logic [GW-1:0]     invert1;
    logic [NUM_IN-1:0] bus_value;
    logic [GW-1:0]     next_sel_low;
    logic [GW-1:0]     next_sel_high;
    logic [15:0]       next_filt_cycles;
    logic [15:0]       next_alarm_filt;
    logic [GW-1:0]     next_invert1;
    logic [NUM_IN-1:0] next_bus_value;

    // copies in force, loaded at restart
    logic [GW-1:0]     act_sel_low;
    logic [GW-1:0]     act_sel_high;
    logic [GW-1:0]     act_invert1;
    logic [GW-1:0]     next_act_sel_low;
    logic [GW-1:0]     next_act_sel_high;
    logic [GW-1:0]     next_act_invert1;

    // bus slave
    logic [DIC_DATA_W-1:0] next_prdata;
    logic                  next_pready;
    logic                  next_pslverr;
    logic                  setup;
    logic                  wr_en;
    logic                  addr_ok;
    logic                  restart;
    logic [15:0]           wdata16;

    // datapath
    logic [NUM_IN-1:0] selected;
    logic [NUM_IN-1:0] conditioned;
    logic [NUM_IN-1:0] filt_q;
    logic [FILT_W-1:0] filt_limit;

    // alarm filter
    logic [DIC_ALARM_CNT_W-1:0] alarm_held;
    logic [DIC_ALARM_CNT_W-1:0] next_alarm_held;
    logic [DIC_ALARM_CNT_W-1:0] alarm_limit;
    logic                       next_alarm_out;

    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pready && pwrite;
    assign wdata16 = pwdata[15:0];
    assign restart = wr_en && (paddr == DIC_OFS_CONTROL) && pwdata[DIC_CTRL_RESTART_BIT];

    always_comb begin
        unique case (paddr)
            DIC_OFS_SEL_LOW, DIC_OFS_SEL_HIGH, DIC_OFS_FILT, DIC_OFS_ALARM_FILT,
            DIC_OFS_INVERT1, DIC_OFS_BUS_VALUE, DIC_OFS_CONTROL, DIC_OFS_STATUS,
            DIC_OFS_ACTIVE: addr_ok = 1'b1;
            default:        addr_ok = 1'b0;
        endcase
    end

    // register writes land at the access edge that completes the transfer
    always_comb begin
        next_sel_low     = sel_low;
        next_sel_high    = sel_high;
        next_filt_cycles = filt_cycles;
        next_alarm_filt  = alarm_filt;
        next_invert1     = invert1;
        next_bus_value   = bus_value;
        if (wr_en) begin
            unique case (paddr)
                DIC_OFS_SEL_LOW: begin
                    next_sel_low = pwdata[GW-1:0];
                end
                DIC_OFS_SEL_HIGH: begin
                    next_sel_high = pwdata[GW-1:0];
                end
                DIC_OFS_FILT: begin
                    next_filt_cycles = (wdata16 > DIC_FILT_MAX) ? DIC_FILT_MAX
                                                                : wdata16;
                end
                DIC_OFS_ALARM_FILT: begin
                    next_alarm_filt = (wdata16 > DIC_ALARM_MAX) ? DIC_ALARM_MAX
                                                                : wdata16;
                end
                DIC_OFS_INVERT1: begin
                    next_invert1 = pwdata[GW-1:0];
                end
                DIC_OFS_BUS_VALUE: begin
                    next_bus_value = pwdata[NUM_IN-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // restart-only settings are copied into force by a restart command
    always_comb begin
        next_act_sel_low  = act_sel_low;
        next_act_sel_high = act_sel_high;
        next_act_invert1  = act_invert1;
        if (restart) begin
            next_act_sel_low  = sel_low;
            next_act_sel_high = sel_high;
            next_act_invert1  = invert1;
        end
    end

    // read data and handshake, registered
    always_comb begin
        next_prdata  = '0;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (setup) begin
            next_pready  = 1'b1;
            next_pslverr = !addr_ok;
            if (!pwrite) begin
                unique case (paddr)
                    DIC_OFS_SEL_LOW: begin
                        next_prdata[GW-1:0] = sel_low;
                    end
                    DIC_OFS_SEL_HIGH: begin
                        next_prdata[GW-1:0] = sel_high;
                    end
                    DIC_OFS_FILT: begin
                        next_prdata[15:0] = filt_cycles;
                    end
                    DIC_OFS_ALARM_FILT: begin
                        next_prdata[15:0] = alarm_filt;
                    end
                    DIC_OFS_INVERT1: begin
                        next_prdata[GW-1:0] = invert1;
                    end
                    DIC_OFS_BUS_VALUE: begin
                        next_prdata[NUM_IN-1:0] = bus_value;
                    end
                    DIC_OFS_STATUS: begin
                        next_prdata[DIC_STAT_FILTERED_LSB +: NUM_IN] = filt_q;
                        next_prdata[DIC_STAT_RAW_LSB +: NUM_IN]      = conditioned;
                        next_prdata[DIC_STAT_ALARM_BIT]              = alarm_out;
                        next_prdata[DIC_STAT_ALARM_RAW_BIT]          = alarm_in;
                    end
                    DIC_OFS_ACTIVE: begin
                        next_prdata[DIC_ACT_SEL_LOW_LSB +: GW]  = act_sel_low;
                        next_prdata[DIC_ACT_SEL_HIGH_LSB +: GW] = act_sel_high;
                        next_prdata[DIC_ACT_INVERT_LSB +: GW]   = act_invert1;
                        next_prdata[DIC_ACT_PENDING_BIT] = (act_sel_low != sel_low)
                                                        || (act_sel_high != sel_high)
                                                        || (act_invert1 != invert1);
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_low      <= DIC_RST_SEL_LOW;
            sel_high     <= DIC_RST_SEL_HIGH;
            filt_cycles  <= DIC_RST_FILT;
            alarm_filt   <= DIC_RST_ALARM_FILT;
            invert1      <= DIC_RST_INVERT1;
            bus_value    <= DIC_RST_BUS_VALUE;
            act_sel_low  <= DIC_RST_SEL_LOW;
            act_sel_high <= DIC_RST_SEL_HIGH;
            act_invert1  <= DIC_RST_INVERT1;
            prdata       <= '0;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
        end else if (ce) begin
            sel_low      <= next_sel_low;
            sel_high     <= next_sel_high;
            filt_cycles  <= next_filt_cycles;
            alarm_filt   <= next_alarm_filt;
            invert1      <= next_invert1;
            bus_value    <= next_bus_value;
            act_sel_low  <= next_act_sel_low;
            act_sel_high <= next_act_sel_high;
            act_invert1  <= next_act_invert1;
            prdata       <= next_prdata;
            pready       <= next_pready;
            pslverr      <= next_pslverr;
        end
    end

    // source select per input, then inversion on the low group
    always_comb begin
        selected = io_connector_in;
        for (int i = 0; i < GW; i++) begin
            if (act_sel_low[i]) begin
                selected[i] = bus_value[i];
            end
            if (act_sel_high[i]) begin
                selected[GW+i] = bus_value[GW+i];
            end
        end
        conditioned = selected;
        conditioned[GW-1:0] = selected[GW-1:0] ^ act_invert1;
    end

    assign filt_limit = FILT_W'(filt_cycles);

    // one glitch filter per input, length taken live from the staged register
    for (genvar g = 0; g < NUM_IN; g++) begin : gen_filt
        dic_filter #(
            .CNT_W (FILT_W)
        ) u_filt (
            .clk      (pclk),
            .rst_n    (presetn),
            .ce       (ce),
            .raw      (conditioned[g]),
            .limit    (filt_limit),
            .filtered (filt_q[g])
        );
    end

    // output copy keeps the port on a flip-flop of this module
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_filtered <= '0;
        end else if (ce) begin
            input_filtered <= filt_q;
        end
    end

    // alarm: assert once high for two cycles per setting step, release at once
    assign alarm_limit = DIC_ALARM_CNT_W'(alarm_filt[1:0] * DIC_ALARM_UNIT);

    always_comb begin
        next_alarm_held = '0;
        next_alarm_out  = 1'b0;
        if (alarm_in) begin
            next_alarm_out = (alarm_held >= alarm_limit);
            next_alarm_held = (alarm_held >= alarm_limit) ? alarm_held
                                                          : alarm_held + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_held <= '0;
            alarm_out  <= 1'b0;
        end else if (ce) begin
            alarm_held <= next_alarm_held;
            alarm_out  <= next_alarm_out;
        end
    end
endmodule
`default_nettype wire

// ==== shared/dic_pkg.sv ====
// constants for the digital input conditioning block
// assumes a single control-cycle clock; one pclk edge is one control cycle
package dic_pkg;
    localparam int unsigned DIC_ADDR_W         = 8;
    localparam int unsigned DIC_DATA_W         = 32;
    localparam int unsigned DIC_GROUP_W        = 4;
    localparam int unsigned DIC_NUM_IN         = 8;
    localparam int unsigned DIC_FILT_W         = 16;
    localparam int unsigned DIC_ALARM_CNT_W    = 3;

    // register byte addresses
    localparam logic [7:0] DIC_OFS_SEL_LOW     = 8'h00;
    localparam logic [7:0] DIC_OFS_SEL_HIGH    = 8'h04;
    localparam logic [7:0] DIC_OFS_FILT        = 8'h08;
    localparam logic [7:0] DIC_OFS_ALARM_FILT  = 8'h0c;
    localparam logic [7:0] DIC_OFS_INVERT1     = 8'h10;
    localparam logic [7:0] DIC_OFS_BUS_VALUE   = 8'h14;
    localparam logic [7:0] DIC_OFS_CONTROL     = 8'h18;
    localparam logic [7:0] DIC_OFS_STATUS      = 8'h1c;
    localparam logic [7:0] DIC_OFS_ACTIVE      = 8'h20;

    // reset values
    localparam logic [3:0]  DIC_RST_SEL_LOW    = 4'h0;
    localparam logic [3:0]  DIC_RST_SEL_HIGH   = 4'h0;
    localparam logic [15:0] DIC_RST_FILT       = 16'h0001;
    localparam logic [15:0] DIC_RST_ALARM_FILT = 16'h0001;
    localparam logic [3:0]  DIC_RST_INVERT1    = 4'h0;
    localparam logic [7:0]  DIC_RST_BUS_VALUE  = 8'h00;

    // setting limits and units
    localparam logic [15:0] DIC_FILT_MAX       = 16'd1000;
    localparam logic [15:0] DIC_ALARM_MAX      = 16'd3;
    localparam int unsigned DIC_ALARM_UNIT     = 2;

    // field positions
    localparam int unsigned DIC_CTRL_RESTART_BIT   = 0;
    localparam int unsigned DIC_STAT_FILTERED_LSB  = 0;
    localparam int unsigned DIC_STAT_RAW_LSB       = 8;
    localparam int unsigned DIC_STAT_ALARM_BIT     = 16;
    localparam int unsigned DIC_STAT_ALARM_RAW_BIT = 17;
    localparam int unsigned DIC_ACT_SEL_LOW_LSB    = 0;
    localparam int unsigned DIC_ACT_SEL_HIGH_LSB   = 4;
    localparam int unsigned DIC_ACT_INVERT_LSB     = 8;
    localparam int unsigned DIC_ACT_PENDING_BIT    = 12;
endpackage
